// ===== core/pss_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the port spin-up and presence controller.
// Assumes a 32-bit APB slave decoding 8 address bits.
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// Byte offsets of the registers, one aligned word each.
`define PSS_OFF_CAP      8'h00
`define PSS_OFF_CMD      8'h04
`define PSS_OFF_CTL      8'h08
`define PSS_OFF_STAT     8'h0c
`define PSS_OFF_IRQST    8'h10
`define PSS_OFF_IRQMSK   8'h14

// Capability register fields.
`define PSS_CAP_STAGGER  0
`define PSS_CAP_COLDCAP  1

// Port command register fields.
`define PSS_CMD_SPINUP   0
`define PSS_CMD_PWRON    1
`define PSS_CMD_COLDCAP  2
`define PSS_CMD_COLDIN   3

// Detect-initialization control field, bits 3:0 of the control word.
`define PSS_DIC_MSB      3
`define PSS_DIC_NORMAL   4'h0
`define PSS_DIC_RESET    4'h1
`define PSS_DIC_OFF      4'h4
`define PSS_DIC_RST_VAL  4'h0

// Phy mode codes shown in the status register.
`define PSS_MODE_LISTEN  3'h0
`define PSS_MODE_NORMAL  3'h1
`define PSS_MODE_RESET   3'h2
`define PSS_MODE_ILLEGAL 3'h3
`define PSS_MODE_OFF     3'h4
`define PSS_MODE_OTHER   3'h5

// Interrupt status and mask bit positions.
`define PSS_IRQ_XDIAG    0
`define PSS_IRQ_WAKE     1
`define PSS_IRQ_PRES     2
`define PSS_IRQ_INIT     3
`define PSS_IRQ_W        4

// Length of the COMRESET burst sent before link initialization.
`define PSS_COMRESET_NS  1000
`define PSS_CLK_NS       4
// Burst length in clocks, sized to the counter: 1000 ns at 4 ns a clock.
`define PSS_COMRESET_CYC 16'h00fa

`endif

// ===== core/pss_phy_mode.v
// Phy mode decoder: maps the detect-initialization control field and
// the spin-up-device bit onto a phy mode, and flags the spin-up and
// initialize transitions as one-cycle events.
// Assumes its inputs are registers in the ref_clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "pss_regs.vh"

module pss_phy_mode (
    input  wire       ref_clk,
    input  wire       reset_n,
    input  wire [3:0] detectInitControl,
    input  wire       spinUpDevice,
    output wire [2:0] phyMode,
    output wire       spinUpEvt,
    output wire       initEvt
);

    // Previous control field and spin-up bit, one clock behind.
    reg [3:0] prevDic;
    reg       prevSpinUp;

    // Decodes a field and spin-up pair into a mode code.
    function [2:0] decodeMode;
        input [3:0] dic;
        input       spin;
        begin
            if (dic == `PSS_DIC_NORMAL) begin
                decodeMode = spin ? `PSS_MODE_NORMAL : `PSS_MODE_LISTEN;
            end else if (dic == `PSS_DIC_RESET) begin
                decodeMode = spin ? `PSS_MODE_RESET : `PSS_MODE_ILLEGAL;
            end else if (dic == `PSS_DIC_OFF) begin
                decodeMode = `PSS_MODE_OFF;
            end else begin
                decodeMode = `PSS_MODE_OTHER;
            end
        end
    endfunction

    // Keeps last cycle's values so transitions become edges.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            prevDic    <= `PSS_DIC_RST_VAL;
            prevSpinUp <= 1'b0;
        end else begin
            prevDic    <= detectInitControl;
            prevSpinUp <= spinUpDevice;
        end
    end

    // Current mode from the present field and bit.
    assign phyMode = decodeMode(detectInitControl, spinUpDevice);

    // Spin-up: bit rises while the field is at 0h.
    assign spinUpEvt = (detectInitControl == `PSS_DIC_NORMAL) &&
                       (prevDic == `PSS_DIC_NORMAL) &&
                       spinUpDevice && !prevSpinUp;

    // Initialize: field falls from 1h to 0h with the bit set.
    assign initEvt = (detectInitControl == `PSS_DIC_NORMAL) &&
                     (prevDic == `PSS_DIC_RESET) &&
                     spinUpDevice && prevSpinUp;

endmodule
`default_nettype wire

// ===== core/pss_port_ctrl.v
// Per-port spin-up, out-of-band mode and cold presence power control.
// Holds the APB register file, the interrupt status and mask, and the
// sequencer that issues COMRESET bursts and link initialization.
// Assumes the out-of-band detector gives one-cycle pulses on ref_clk
// and that the presence pin is already synchronous to ref_clk.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pss_regs.vh"

// Notes on behaviour
// - cold capable port reports bit, presence pin, power pin
// - power bit writable, resets off, drives switch
// - staggered support sets capability, spin-up bit writable
// - no staggered support: spin-up bit fixed one
// - listen: COMINIT sets diag flag, no reply
// - listen forces phy low power, no negotiation
// - spin-up bit rising at 0h sends COMRESET, init
// - normal: COMINIT flags, resets, reinitializes; COMWAKE wakes
// - reset mode sends COMRESET continuously, COMINIT sets diag flag only
// - field 1h to 0h stops COMRESET, starts init
module pss_port_ctrl #(
    parameter        STAGGER_SUPPORT = 1,  // Staggered spin-up present.
    parameter        COLD_PRESENCE   = 1,  // Cold presence on this port.
    parameter [15:0] COMRESET_CYCLES = `PSS_COMRESET_CYC
) (
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        comInitRx,
    input  wire        comWakeRx,
    input  wire        coldPresenceIn,
    input  wire [3:0]  deviceDetectStatus,
    output reg         comResetTx,
    output reg         linkInitStart,
    output reg         linkWake,
    output reg         phyLowPower,
    output reg         phyOffline,
    output reg         devicePowerEn,
    output reg         irq
);

    // Sequencer states.
    localparam [1:0] ST_IDLE  = 2'd0;  // No burst in progress.
    localparam [1:0] ST_BURST = 2'd1;  // Sending a COMRESET burst.
    localparam [1:0] ST_INIT  = 2'd2;  // Issuing link initialization.

    // Capability values seen by software.
    localparam STG = (STAGGER_SUPPORT != 0) ? 1'b1 : 1'b0;
    localparam CPC = (COLD_PRESENCE != 0) ? 1'b1 : 1'b0;

    // Software-visible control state.
    reg [3:0]  detectInitControl;   // Detect-initialization field.
    reg        spinUpDevice;        // Spin-up-device bit.
    reg        powerOnDevice;       // Power-on-device bit.
    reg [`PSS_IRQ_W-1:0] irqStatus; // Sticky event bits.
    reg [`PSS_IRQ_W-1:0] irqMask;   // Enables for the event bits.

    // Sequencer state and burst counter.
    reg [1:0]  seqState;
    reg [1:0]  next_seqState;
    reg [15:0] burstCount;
    reg [15:0] next_burstCount;

    // Last sampled presence pin, for change detection.
    reg        prevPresence;

    // Decoded mode and transition events from the decoder.
    wire [2:0] phyMode;
    wire       spinUpEvt;
    wire       initEvt;

    // Bus qualifiers.
    wire       setupPhase;          // First cycle of a transfer.
    wire       wrDone;              // Write takes effect this edge.
    wire [7:0] wordAddr;            // Address with byte bits cleared.
    reg        addrHit;             // Address names a register.
    reg [31:0] readValue;           // Read data for the address.

    // Event pulses raised this cycle.
    wire       xdiagEvt;
    wire       wakeEvt;
    wire       presEvt;
    wire       startInit;
    wire       startBurst;
    wire [`PSS_IRQ_W-1:0] irqSet;
    wire [`PSS_IRQ_W-1:0] irqClr;

    // Mode decoder and transition edge detector.
    pss_phy_mode uMode (
        .ref_clk           (ref_clk),
        .reset_n           (reset_n),
        .detectInitControl (detectInitControl),
        .spinUpDevice      (spinUpDevice),
        .phyMode           (phyMode),
        .spinUpEvt         (spinUpEvt),
        .initEvt           (initEvt)
    );

    // Transfer is in setup when selected without enable.
    assign setupPhase = psel && !penable;

    // The write lands at the edge where the master sees ready.
    assign wrDone = psel && penable && pready && pwrite;

    // Word address for decode; byte lane bits are ignored.
    assign wordAddr = {paddr[7:2], 2'b00};

    // Builds the read value and marks mapped addresses.
    always @* begin
        readValue = 32'h0000_0000;
        addrHit   = 1'b1;
        case (wordAddr)
            `PSS_OFF_CAP: begin
                // Capability bits are fixed by the build.
                readValue[`PSS_CAP_STAGGER] = STG;
                readValue[`PSS_CAP_COLDCAP] = CPC;
            end
            `PSS_OFF_CMD: begin
                // Cold capable bit and presence pin level.
                readValue[`PSS_CMD_SPINUP]  = spinUpDevice;
                readValue[`PSS_CMD_PWRON]   = powerOnDevice;
                readValue[`PSS_CMD_COLDCAP] = CPC;
                readValue[`PSS_CMD_COLDIN]  = CPC & prevPresence;
            end
            `PSS_OFF_CTL: begin
                // Control field as written.
                readValue[`PSS_DIC_MSB:0] = detectInitControl;
            end
            `PSS_OFF_STAT: begin
                // Mode, sequencer and drive detect status.
                readValue[2:0]  = phyMode;
                readValue[4:3]  = seqState;
                readValue[5]    = comResetTx;
                readValue[11:8] = deviceDetectStatus;
            end
            `PSS_OFF_IRQST: begin
                // Sticky events.
                readValue[`PSS_IRQ_W-1:0] = irqStatus;
            end
            `PSS_OFF_IRQMSK: begin
                // Interrupt enables.
                readValue[`PSS_IRQ_W-1:0] = irqMask;
            end
            default: begin
                // Unmapped address answers with an error.
                addrHit = 1'b0;
            end
        endcase
    end

    // A status read returns the word as it stood at the setup edge; an
    // event raised in the access cycle shows on the following read.
    // Answers every transfer after one access cycle; read data and the
    // error flag are captured in the setup cycle.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= setupPhase;
            if (setupPhase) begin
                pslverr <= !addrHit;
                prdata  <= pwrite ? 32'h0000_0000 : readValue;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control register writes.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            detectInitControl <= `PSS_DIC_RST_VAL;
            // Spin-up bit is fixed at one without staggering.
            spinUpDevice  <= !STG;
            // Power withheld at start on a cold capable port.
            powerOnDevice <= !CPC;
            irqMask       <= {`PSS_IRQ_W{1'b0}};
        end else if (wrDone && addrHit) begin
            if (wordAddr == `PSS_OFF_CTL) begin
                detectInitControl <= pwdata[`PSS_DIC_MSB:0];
            end
            if (wordAddr == `PSS_OFF_CMD) begin
                // Writable only with staggered support.
                if (STG) begin
                    spinUpDevice <= pwdata[`PSS_CMD_SPINUP];
                end
                // Writable only on a cold capable port.
                if (CPC) begin
                    powerOnDevice <= pwdata[`PSS_CMD_PWRON];
                end
            end
            if (wordAddr == `PSS_OFF_IRQMSK) begin
                irqMask <= pwdata[`PSS_IRQ_W-1:0];
            end
        end
    end

    // The illegal pairing of 1h with the spin-up bit clear is kept
    // quiet: no flag, no COMRESET and an idle sequencer, so a software
    // slip cannot disturb an attached drive.
    // Exchanged flag on COMINIT in listen, normal and reset. The
    // illegal combination never raises it.
    assign xdiagEvt = comInitRx &&
                      ((phyMode == `PSS_MODE_LISTEN) ||
                       (phyMode == `PSS_MODE_NORMAL) ||
                       (phyMode == `PSS_MODE_RESET));

    // COMWAKE counts only in normal; listen ignores it.
    assign wakeEvt = comWakeRx && (phyMode == `PSS_MODE_NORMAL);

    // Presence pin change on a cold capable port.
    assign presEvt = CPC && (coldPresenceIn != prevPresence);

    // Burst on spin-up or on COMINIT in normal mode.
    assign startBurst = spinUpEvt ||
                        (comInitRx && (phyMode == `PSS_MODE_NORMAL));

    // Leaving reset goes straight to initialization.
    assign startInit = initEvt;

    // Event and clear vectors for the sticky status.
    assign irqSet = {linkInitStart, presEvt, wakeEvt, xdiagEvt};
    assign irqClr = (wrDone && (wordAddr == `PSS_OFF_IRQST)) ?
                    pwdata[`PSS_IRQ_W-1:0] : {`PSS_IRQ_W{1'b0}};

    // Sticky status, write one to clear; a new event beats the clear.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            irqStatus    <= {`PSS_IRQ_W{1'b0}};
            prevPresence <= 1'b0;
            irq          <= 1'b0;
        end else begin
            irqStatus    <= (irqStatus & ~irqClr) | irqSet;
            prevPresence <= coldPresenceIn;
            irq          <= |(irqStatus & irqMask);
        end
    end

    // A COMINIT that lands mid-burst reloads the counter, so the drive
    // sees one full-length COMRESET before an initialization that ends a burst.
    // Leaving reset mode skips the burst: COMRESET has been sent for as
    // long as software held the field at 1h.
    // Sequencer next state: bursts, initialization and mode overrides.
    always @* begin
        next_seqState   = seqState;
        next_burstCount = burstCount;
        case (phyMode)
            `PSS_MODE_NORMAL: begin
                if (startInit) begin
                    // Stop COMRESET and initialize at once.
                    next_seqState   = ST_INIT;
                    next_burstCount = 16'h0000;
                end else if (startBurst) begin
                    // Restart a burst even mid-sequence.
                    next_seqState   = ST_BURST;
                    next_burstCount = COMRESET_CYCLES;
                end else begin
                    case (seqState)
                        ST_BURST: begin
                            // Count down the COMRESET burst.
                            if (burstCount <= 16'h0001) begin
                                next_seqState   = ST_INIT;
                                next_burstCount = 16'h0000;
                            end else begin
                                next_burstCount = burstCount - 16'h0001;
                            end
                        end
                        ST_INIT: begin
                            // One cycle of initialization request.
                            next_seqState = ST_IDLE;
                        end
                        default: begin
                            next_seqState = ST_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                // Other modes hold the sequencer idle; reset mode
                // drives COMRESET directly.
                next_seqState   = ST_IDLE;
                next_burstCount = 16'h0000;
            end
        endcase
    end

    // Sequencer registers.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            seqState   <= ST_IDLE;
            burstCount <= 16'h0000;
        end else begin
            seqState   <= next_seqState;
            burstCount <= next_burstCount;
        end
    end

    // Phy control outputs, each from its own flip-flop.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            comResetTx    <= 1'b0;
            linkInitStart <= 1'b0;
            linkWake      <= 1'b0;
            phyLowPower   <= 1'b0;
            phyOffline    <= 1'b0;
            devicePowerEn <= 1'b0;
        end else begin
            // Continuous in reset mode, else during a burst.
            comResetTx <= (phyMode == `PSS_MODE_RESET) ||
                          (next_seqState == ST_BURST);
            // One-cycle start of link initialization.
            linkInitStart <= (next_seqState == ST_INIT);
            // Wake the link on COMWAKE in normal mode.
            linkWake <= wakeEvt;
            // Low power forced locally in listen, nothing sent on the
            // link and no reply to COMINIT.
            phyLowPower <= (phyMode == `PSS_MODE_LISTEN);
            // Off mode takes the phy offline.
            phyOffline <= (phyMode == `PSS_MODE_OFF);
            // Power switch follows the power-on bit.
            devicePowerEn <= powerOnDevice;
        end
    end

endmodule
`default_nettype wire

// ===== dv/pss_port_ctrl_props.sv
// Checker watching the ports of the port spin-up controller.
// Assumes one ref_clk domain with a synchronous active-low reset_n.
`timescale 1ns/10ps
`default_nettype none
module pss_port_ctrl_props #(
    parameter [15:0] COMRESET_CYCLES = 16'h0004
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comWakeRx,
    input wire logic comResetTx,
    input wire logic linkInitStart,
    input wire logic linkWake,
    input wire logic phyLowPower,
    input wire logic phyOffline,
    input wire logic devicePowerEn
);
    // All checks share the one clock and its reset.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // The slave answers one cycle after every setup.
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_power_reset: assert property (!$past(reset_n) |-> !devicePowerEn)
        else $error("drive powered out of reset");
    a_burst_held: assert property ($rose(comResetTx) |-> comResetTx[*3])
        else $error("reset burst cut short");
    a_init_after_rst: assert property (linkInitStart |-> $past(comResetTx))
        else $error("init without preceding reset burst");
    a_init_pulse: assert property (linkInitStart |=> !linkInitStart)
        else $error("init event longer than one cycle");
    a_wake_cause: assert property (linkWake |-> !phyLowPower &&
        ($past(comWakeRx) || $past(comWakeRx, 2)))
        else $error("wake without cause or in listen");
    a_listen_quiet: assert property (phyLowPower |-> !comResetTx && !phyOffline)
        else $error("listen mode not quiet");
    // Main scenarios reached.
    c_init: cover property (linkInitStart);
    c_wake: cover property (linkWake);
    c_err: cover property (pslverr);
endmodule
bind pss_port_ctrl pss_port_ctrl_props #(.COMRESET_CYCLES(COMRESET_CYCLES))
    u_pss_port_ctrl_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .comWakeRx(comWakeRx), .comResetTx(comResetTx),
    .linkInitStart(linkInitStart), .linkWake(linkWake),
    .phyLowPower(phyLowPower), .phyOffline(phyOffline),
    .devicePowerEn(devicePowerEn));
`default_nettype wire

// ===== dv/pss_drive_model.sv
// Behavioural model of the drive across the serial link.
// Assumes the bench requests out-of-band signals with one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module pss_drive_model #(
    parameter [3:0] DET_PRESENT = 4'h3  // Detect status while plugged.
) (
    input  wire logic       ref_clk,
    input  wire logic       attached,   // Drive is plugged in.
    input  wire logic       sendInit,   // Request one COMINIT.
    input  wire logic       sendWake,   // Request one COMWAKE.
    input  wire logic [3:0] lag,        // Reply delay in cycles.
    output var  logic       comInitRx,
    output var  logic       comWakeRx,
    output wire logic       coldPresenceIn,
    output wire logic [3:0] deviceDetectStatus
);
    logic [3:0] cnt;    // Cycles left before the signal goes out.
    logic       pendI;  // COMINIT waiting.
    logic       pendW;  // COMWAKE waiting.
    initial begin
        cnt = 4'h0;
        pendI = 1'b0;
        pendW = 1'b0;
        comInitRx = 1'b0;
        comWakeRx = 1'b0;
    end
    // Holds a request for lag cycles; an unplugged drive sends nothing.
    always @(posedge ref_clk) begin
        comInitRx <= 1'b0;
        comWakeRx <= 1'b0;
        if (sendInit || sendWake) begin
            pendI <= sendInit;
            pendW <= sendWake;
            cnt <= lag;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (attached) begin
            comInitRx <= pendI;
            comWakeRx <= pendW;
            pendI <= 1'b0;
            pendW <= 1'b0;
        end
    end
    // Presence and detect status follow the plug.
    assign coldPresenceIn = attached;
    assign deviceDetectStatus = attached ? DET_PRESENT : 4'h0;
endmodule
`default_nettype wire

// ===== dv/pss_port_ctrl_tb.sv
// Self-checking bench for the port spin-up and presence controller.
// Assumes the drive model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "pss_regs.vh"
module pss_port_ctrl_tb;
    localparam [15:0] CR = 16'h0004;  // Shortened reset burst.
    logic        ref_clk, reset_n;    // Clock and reset.
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;   // Bus data and last read.
    logic        pready, pslverr, lastErr;
    logic        comInitRx, comWakeRx, coldPresenceIn;
    logic [3:0]  deviceDetectStatus, lag;
    logic        comResetTx, linkInitStart, linkWake, phyLowPower;
    logic        phyOffline, devicePowerEn, irq;
    logic        attached, sendInit, sendWake;
    logic [31:0] d;
    int          err_count, samples_checked, n;

    pss_port_ctrl #(.COMRESET_CYCLES(CR)) u_pss_port_ctrl (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comInitRx(comInitRx), .comWakeRx(comWakeRx),
        .coldPresenceIn(coldPresenceIn),
        .deviceDetectStatus(deviceDetectStatus), .comResetTx(comResetTx),
        .linkInitStart(linkInitStart), .linkWake(linkWake),
        .phyLowPower(phyLowPower), .phyOffline(phyOffline),
        .devicePowerEn(devicePowerEn), .irq(irq));
    pss_drive_model u_pss_drive_model (
        .ref_clk(ref_clk), .attached(attached), .sendInit(sendInit),
        .sendWake(sendWake), .lag(lag), .comInitRx(comInitRx),
        .comWakeRx(comWakeRx), .coldPresenceIn(coldPresenceIn),
        .deviceDetectStatus(deviceDetectStatus));

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    // One bus transfer; the read word lands in q.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits for a flag, counting edges, with a bound.
    task automatic waitFor(ref logic s, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (s !== 1'b1 && c < 50);
    endtask
    // Asks the drive for one out-of-band signal, then waits hold edges.
    task automatic pulse(input logic i, w, input int hold);
        lag <= 4'($urandom_range(7, 0));
        sendInit <= i;
        sendWake <= w;
        @(posedge ref_clk);
        sendInit <= 1'b0;
        sendWake <= 1'b0;
        repeat (hold) @(posedge ref_clk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        #40000;
        err_count++;
        results;
    end

    // Main sequence.
    initial begin
        void'($urandom(9));
        {reset_n, psel, penable, pwrite, attached, sendInit, sendWake} = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lag = 4'h0;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(0, `PSS_OFF_CAP, 0);
        chk("cap", 32'h3, q);
        apb(0, `PSS_OFF_CMD, 0);
        chk("cmd", 32'h4, q);
        chk("listen", 1, phyLowPower);
        apb(1, `PSS_OFF_CMD, 2);
        repeat (2) @(posedge ref_clk);
        chk("power", 1, devicePowerEn);
        $display("test reset and power done");
        attached <= 1'b1;
        pulse(1, 0, 12);
        chk("listen reply", 0, comResetTx);
        pulse(0, 1, 12);
        apb(0, `PSS_OFF_IRQST, 0);
        chk("xdiag", 1, q[0]);
        chk("wake ignored", 0, q[1]);
        apb(1, `PSS_OFF_IRQMSK, 1);
        repeat (2) @(posedge ref_clk);
        chk("irq on", 1, irq);
        apb(1, `PSS_OFF_IRQST, 1);
        repeat (2) @(posedge ref_clk);
        chk("irq off", 0, irq);
        apb(0, 8'h40, 0);
        chk("slverr", 1, lastErr);
        $display("test listen done");
        apb(1, `PSS_OFF_CMD, 3);
        waitFor(linkInitStart, n);
        chk("spinup delay", CR + 2, n);
        chk("awake", 0, phyLowPower);
        pulse(1, 0, 0);
        waitFor(linkInitStart, n);
        chk("reinit", 1, linkInitStart);
        apb(0, `PSS_OFF_IRQST, 0);
        chk("xdiag normal", 1, q[0]);
        pulse(0, 1, 0);
        waitFor(linkWake, n);
        chk("wake", 1, linkWake);
        $display("test spin-up and normal done");
        apb(1, `PSS_OFF_CTL, 1);
        repeat ($urandom_range(30, 10)) @(posedge ref_clk);
        chk("reset held", 1, comResetTx);
        pulse(1, 0, 12);
        chk("reset still", 1, comResetTx);
        apb(1, `PSS_OFF_CTL, 0);
        waitFor(linkInitStart, n);
        chk("init delay", 2, n);
        chk("reset stop", 0, comResetTx);
        $display("test reset mode done");
        repeat (12) @(posedge ref_clk);
        apb(1, `PSS_OFF_CTL, 4);
        repeat (2) @(posedge ref_clk);
        chk("offline", 1, phyOffline);
        apb(0, `PSS_OFF_STAT, 0);
        chk("mode off", `PSS_MODE_OFF, q[2:0]);
        apb(1, `PSS_OFF_CTL, 2);
        apb(0, `PSS_OFF_STAT, 0);
        chk("mode other", `PSS_MODE_OTHER, q[2:0]);
        apb(1, `PSS_OFF_CTL, 0);
        attached <= 1'b0;
        repeat (12) @(posedge ref_clk);
        apb(0, `PSS_OFF_STAT, 0);
        chk("no drive", 0, q[11:8]);
        apb(1, `PSS_OFF_CMD, 2);
        repeat (2) @(posedge ref_clk);
        chk("relisten", 1, phyLowPower);
        repeat (4) begin
            d = $urandom;
            apb(1, `PSS_OFF_IRQMSK, d);
            apb(0, `PSS_OFF_IRQMSK, 0);
            chk("mask", d & 32'hf, q);
        end
        $display("test offline and mask done");
        results;
    end
endmodule
`default_nettype wire
